// ==== hw/ppf_defs.svh ====
// register offsets, field positions, reset values and timer encodings for the port block
// assumes inclusion by bare name from any file that needs these constants
`ifndef PPF_DEFS_SVH
`define PPF_DEFS_SVH

// register offsets on the plain register port
`define PPF_OFF_P1_DATA     8'h00
`define PPF_OFF_P1_DIR      8'h01
`define PPF_OFF_P1_PULL     8'h02
`define PPF_OFF_P1_MODE     8'h03
`define PPF_OFF_P3_DATA     8'h04
`define PPF_OFF_P3_DIR      8'h05

// reset values
`define PPF_RST_P1_DATA     3'h0
`define PPF_RST_P1_DIR      7'h00
`define PPF_RST_P1_PULL     7'h00
`define PPF_RST_P1_MODE     2'h0
`define PPF_RST_P3_DATA     8'h00
`define PPF_RST_P3_DIR      8'h00

// field positions and fixed read patterns
`define PPF_MODE_EVL_BIT    1
`define PPF_MODE_EVH_BIT    0
`define PPF_P3_IMPL_MASK    8'hc7
`define PPF_ALL_ONES        8'hff
`define PPF_UNMAPPED_READ   8'h00

// timer channel encodings
`define PPF_TMODE_NORMAL    2'h0
`define PPF_TMODE_PWM1      2'h2
`define PPF_TMODE_PWM2      2'h3
`define PPF_CCLR_PWM2_BLOCK 2'h2
`define PPF_TPSC_EXT_A      3'h4

`endif

// ==== hw/ppf_pkg.sv ====
// types shared by the port function select block
// assumes the constants header is included where values are needed
package ppf_pkg;

  // channel 1 timer setting as seen by the pin logic
  typedef struct packed {
    logic [1:0] timer_mode_bits;
    logic [3:0] timer_a_io_ctrl;
    logic [1:0] counter_clear_sel;
    logic [2:0] clock_prescale_sel_1;
    logic [2:0] clock_prescale_sel_2;
  } ppf_timer_cfg_s;

  // decoded function of the channel 1 a-pin
  typedef struct packed {
    logic out_en;
    logic pwm1;
    logic capture;
    logic ext_clock;
  } ppf_a_func_s;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ppf_bus_req_s;

  // whole register state of the top module
  typedef struct packed {
    logic [2:0] port1_data;
    logic [6:0] port1_direction;
    logic [6:0] port1_pullup_ctrl;
    logic [1:0] port1_function_mode;
    logic [7:0] port3_data_latch;
    logic [7:0] port3_direction;
    logic [7:0] rdata;
  } ppf_state_s;

endpackage

// ==== hw/ppf_a_pin_decode.sv ====
// decoder of the channel 1 a-pin function from the timer setting
// assumes the timer setting inputs are stable register outputs of the timer unit
`timescale 1ns/1ps
`include "ppf_defs.svh"

module ppf_a_pin_decode (
  input  wire ppf_pkg::ppf_timer_cfg_s cfg_in,
  output ppf_pkg::ppf_a_func_s         func_out
);

  // an io field of xx00 means no output on this pin
  function automatic logic io_drives(input logic [3:0] io);
    io_drives = (io[1:0] != 2'h0);
  endfunction

  // pin function from mode, io field, clear and prescaler fields
  always_comb begin
    func_out           = '0;
    func_out.ext_clock = (cfg_in.clock_prescale_sel_1 == `PPF_TPSC_EXT_A) ||
                         (cfg_in.clock_prescale_sel_2 == `PPF_TPSC_EXT_A);
    unique case (cfg_in.timer_mode_bits)
      `PPF_TMODE_NORMAL: begin
        func_out.capture = cfg_in.timer_a_io_ctrl[3];
        func_out.out_en  = !cfg_in.timer_a_io_ctrl[3] &&
                           io_drives(cfg_in.timer_a_io_ctrl);
      end
      `PPF_TMODE_PWM1: begin
        func_out.out_en = io_drives(cfg_in.timer_a_io_ctrl);
        func_out.pwm1   = io_drives(cfg_in.timer_a_io_ctrl);
      end
      `PPF_TMODE_PWM2: begin
        // a clear field of b10 makes this pin the period source, so no wave
        func_out.out_en = io_drives(cfg_in.timer_a_io_ctrl) &&
                          (cfg_in.counter_clear_sel != `PPF_CCLR_PWM2_BLOCK);
      end
      default: begin
        func_out.out_en = 1'b0;
      end
    endcase
  end

endmodule // ppf_a_pin_decode

// ==== hw/ppf_top.sv ====
// port 1 pin function select (bits 2..0), port 1 pull-ups, port 3 latch and direction
// assumes the timer, event counter and port 3 peripherals sit outside and pins are synchronous
`timescale 1ns/1ps
`include "ppf_defs.svh"

module ppf_top (
  input  wire logic                   clock_in,
  input  wire logic                   resetn_in,
  // register port
  input  wire logic [7:0]             reg_addr_in,
  input  wire logic [7:0]             reg_wdata_in,
  input  wire logic                   reg_wr_in,
  input  wire logic                   reg_rd_in,
  output      logic [7:0]             reg_rdata_out,
  // timer channel 1 interface
  input  wire ppf_pkg::ppf_timer_cfg_s timer_cfg_in,
  input  wire logic                   timer1_pin_a_wave_in,
  output      logic                   timer1_pin_a_capture_out,
  output      logic                   ext_timer_clock_a_out,
  output      logic                   timer1_pin_b_out_dis_out,
  // event counter inputs
  output      logic                   event_count_low_out,
  output      logic                   event_count_high_out,
  // port 1 bits 2..0 pins, pull-ups for bits 6..0
  input  wire logic [2:0]             port1_pin_in,
  output      logic [2:0]             port1_pin_out,
  output      logic [2:0]             port1_pin_oe_out,
  output      logic [6:0]             port1_pullup_out,
  // port 3 pins
  input  wire logic [7:0]             port3_pin_in,
  input  wire logic [7:0]             port3_alt_func_in,
  output      logic [7:0]             port3_pin_out,
  output      logic [7:0]             port3_pin_oe_out
);

  ppf_pkg::ppf_bus_req_s req;
  ppf_pkg::ppf_state_s   state;
  ppf_pkg::ppf_state_s   next_state;
  ppf_pkg::ppf_a_func_s  a_func;
  logic [1:0]            rst_pipe;
  logic                  rst_n;

  // gather the register port into one carrier
  assign req.addr  = reg_addr_in;
  assign req.wdata = reg_wdata_in;
  assign req.wr    = reg_wr_in;
  assign req.rd    = reg_rd_in;

  // reset released through two flops so release is clean on clock_in
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // channel 1 a-pin function decode
  ppf_a_pin_decode ppf_a_pin_decode_i (
    .cfg_in   (timer_cfg_in),
    .func_out (a_func)
  );

  // port read merge: latch for output bits, pin for input bits
  function automatic logic [7:0] merge_read(input logic [7:0] latch,
                                            input logic [7:0] pin,
                                            input logic [7:0] dir);
    merge_read = (latch & dir) | (pin & ~dir);
  endfunction

  // register writes and registered read data
  always_comb begin
    next_state       = state;
    next_state.rdata = `PPF_UNMAPPED_READ;
    if (req.wr) begin
      unique case (req.addr)
        `PPF_OFF_P1_DATA: next_state.port1_data          = req.wdata[2:0];
        `PPF_OFF_P1_DIR:  next_state.port1_direction     = req.wdata[6:0];
        `PPF_OFF_P1_PULL: next_state.port1_pullup_ctrl   = req.wdata[6:0];
        `PPF_OFF_P1_MODE: next_state.port1_function_mode = req.wdata[1:0];
        // reserved bits 5..3 never stored
        `PPF_OFF_P3_DATA: next_state.port3_data_latch =
                            req.wdata & `PPF_P3_IMPL_MASK;
        `PPF_OFF_P3_DIR:  next_state.port3_direction =
                            req.wdata & `PPF_P3_IMPL_MASK;
        default: begin
          next_state.rdata = `PPF_UNMAPPED_READ;
        end
      endcase
    end
    if (req.rd) begin
      unique case (req.addr)
        `PPF_OFF_P1_DATA: next_state.rdata = merge_read({5'h1f, state.port1_data},
                                                        {5'h1f, port1_pin_in},
                                                        {5'h1f, state.port1_direction[2:0]});
        `PPF_OFF_P1_DIR:  next_state.rdata = {1'b1, state.port1_direction};
        `PPF_OFF_P1_PULL: next_state.rdata = {1'b1, state.port1_pullup_ctrl};
        `PPF_OFF_P1_MODE: next_state.rdata = {6'h3f, state.port1_function_mode};
        // unimplemented bits are forced high after the merge
        `PPF_OFF_P3_DATA: next_state.rdata =
                            merge_read(state.port3_data_latch, port3_pin_in,
                                       state.port3_direction) |
                            ~`PPF_P3_IMPL_MASK;
        `PPF_OFF_P3_DIR:  next_state.rdata = `PPF_ALL_ONES;
        default: begin
          next_state.rdata = `PPF_UNMAPPED_READ;
        end
      endcase
    end
  end

  // single state register; pull-ups start off because the control bits clear
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      state.port1_data          <= `PPF_RST_P1_DATA;
      state.port1_direction     <= `PPF_RST_P1_DIR;
      state.port1_pullup_ctrl   <= `PPF_RST_P1_PULL;
      state.port1_function_mode <= `PPF_RST_P1_MODE;
      state.port3_data_latch    <= `PPF_RST_P3_DATA;
      state.port3_direction     <= `PPF_RST_P3_DIR;
      state.rdata               <= 8'h00;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata_out = state.rdata;

  // a-pin: timer wave wins over the general io path; bit drivers kept as plain
  // assigns so no bit of the pin vectors is shared with a procedural block
  assign port1_pin_oe_out[2] = a_func.out_en ? 1'b1 : state.port1_direction[2];
  assign port1_pin_out[2]    = a_func.out_en ? timer1_pin_a_wave_in : state.port1_data[2];

  // a-pin also feeds the timer as capture and external clock input
  assign timer1_pin_a_capture_out = a_func.capture & port1_pin_in[2];
  assign ext_timer_clock_a_out    = a_func.ext_clock & port1_pin_in[2];
  assign timer1_pin_b_out_dis_out = a_func.pwm1;

  // event counter pins are inputs only while selected
  assign port1_pin_oe_out[1] = !state.port1_function_mode[`PPF_MODE_EVL_BIT] &&
                               state.port1_direction[1];
  assign port1_pin_oe_out[0] = !state.port1_function_mode[`PPF_MODE_EVH_BIT] &&
                               state.port1_direction[0];
  assign port1_pin_out[1:0]  = state.port1_data[1:0];
  assign event_count_low_out  = state.port1_function_mode[`PPF_MODE_EVL_BIT] &
                                port1_pin_in[1];
  assign event_count_high_out = state.port1_function_mode[`PPF_MODE_EVH_BIT] &
                                port1_pin_in[0];

  // pull-up follows the register bits, not the live pin function
  assign port1_pullup_out = state.port1_pullup_ctrl & ~state.port1_direction;

  // port 3 drive; a peripheral owning the pin takes it away from the latch
  assign port3_pin_oe_out = state.port3_direction & `PPF_P3_IMPL_MASK &
                            ~port3_alt_func_in;
  assign port3_pin_out    = state.port3_data_latch & `PPF_P3_IMPL_MASK;

  // checks on the port and pin behaviour
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n);

  sequence s_write(logic [7:0] off);
    req.wr && (req.addr == off);
  endsequence

  sequence s_read(logic [7:0] off);
    req.rd && (req.addr == off);
  endsequence

  property p_pull_write;
    s_write(`PPF_OFF_P1_PULL) ##0 !$past(req.wr) ##1 !req.wr |->
      port1_pullup_out == ($past(req.wdata[6:0]) & ~state.port1_direction);
  endproperty
  a_pull_write: assert property (p_pull_write)
    else $error("pull-up does not follow written control bits");

  property p_pull_reset;
    $rose(rst_n) |-> (port1_pullup_out == 7'h00);
  endproperty
  a_pull_reset: assert property (p_pull_reset)
    else $error("pull-up on after reset");

  property p_p3_read;
    s_read(`PPF_OFF_P3_DATA) |=>
      reg_rdata_out == (merge_read($past(state.port3_data_latch), $past(port3_pin_in),
                                   $past(state.port3_direction)) | 8'h38);
  endproperty
  a_p3_read: assert property (p_p3_read)
    else $error("port 3 read mixes latch and pin wrongly");

  property p_p3_reserved;
    s_write(`PPF_OFF_P3_DATA) |=> (state.port3_data_latch[5:3] == 3'h0);
  endproperty
  a_p3_reserved: assert property (p_p3_reserved)
    else $error("port 3 reserved bits not fixed");

  property p_p3_read_fixed;
    s_read(`PPF_OFF_P3_DATA) |=> (reg_rdata_out[5:3] == 3'h7);
  endproperty
  a_p3_read_fixed: assert property (p_p3_read_fixed)
    else $error("port 3 reserved bits not read as one");

  property p_p3_dir_read;
    s_read(`PPF_OFF_P3_DIR) |=> (reg_rdata_out == 8'hff);
  endproperty
  a_p3_dir_read: assert property (p_p3_dir_read)
    else $error("port 3 direction read not all ones");

  property p_p3_dir_write;
    s_write(`PPF_OFF_P3_DIR) |=>
      port3_pin_oe_out == ($past(req.wdata) & 8'hc7 & ~port3_alt_func_in);
  endproperty
  a_p3_dir_write: assert property (p_p3_dir_write)
    else $error("port 3 output enable wrong after direction write");

  property p_a_timer_out;
    a_func.out_en |-> port1_pin_oe_out[2] && (port1_pin_out[2] == timer1_pin_a_wave_in);
  endproperty
  a_a_timer_out: assert property (p_a_timer_out)
    else $error("timer output not on a-pin");

  property p_a_gpio;
    (timer_cfg_in.timer_mode_bits == 2'h0) && timer_cfg_in.timer_a_io_ctrl[3] |->
      !port1_pin_oe_out[2] || state.port1_direction[2];
  endproperty
  a_a_gpio: assert property (p_a_gpio)
    else $error("a-pin driven while capture setting and input direction");

  property p_pwm;
    (timer_cfg_in.timer_mode_bits == 2'h2) && (timer_cfg_in.timer_a_io_ctrl[1:0] != 2'h0) |->
      timer1_pin_b_out_dis_out && port1_pin_oe_out[2];
  endproperty
  a_pwm: assert property (p_pwm)
    else $error("pwm1 setting not applied");

  property p_pwm2_block;
    (timer_cfg_in.timer_mode_bits == 2'h3) && (timer_cfg_in.counter_clear_sel == 2'h2) &&
      !state.port1_direction[2] |-> !port1_pin_oe_out[2];
  endproperty
  a_pwm2_block: assert property (p_pwm2_block)
    else $error("pwm2 output with blocking clear setting");

  property p_event;
    state.port1_function_mode[1] |-> !port1_pin_oe_out[1] &&
      (event_count_low_out == port1_pin_in[1]);
  endproperty
  a_event: assert property (p_event)
    else $error("low event pin not an input");

  property p_event_high;
    state.port1_function_mode[`PPF_MODE_EVH_BIT] |-> !port1_pin_oe_out[0] &&
      (event_count_high_out == port1_pin_in[0]);
  endproperty
  a_event_high: assert property (p_event_high)
    else $error("high event pin not an input");

  // with the event input off the pin is plain io and the counter sees nothing
  property p_event_low_gpio;
    !state.port1_function_mode[`PPF_MODE_EVL_BIT] |->
      (port1_pin_oe_out[1] == state.port1_direction[1]) && !event_count_low_out;
  endproperty
  a_event_low_gpio: assert property (p_event_low_gpio)
    else $error("low event pin not general io while deselected");

  property p_event_high_gpio;
    !state.port1_function_mode[`PPF_MODE_EVH_BIT] |->
      (port1_pin_oe_out[0] == state.port1_direction[0]) && !event_count_high_out;
  endproperty
  a_event_high_gpio: assert property (p_event_high_gpio)
    else $error("high event pin not general io while deselected");

  // a direction write to output must drop the pull-up in the next cycle
  property p_pull_dir_write;
    s_write(`PPF_OFF_P1_DIR) |=> (port1_pullup_out & $past(req.wdata[6:0])) == 7'h00;
  endproperty
  a_pull_dir_write: assert property (p_pull_dir_write)
    else $error("pull-up left on for an output pin");

  property p_p3_data_write;
    s_write(`PPF_OFF_P3_DATA) |=>
      port3_pin_out == ($past(req.wdata) & `PPF_P3_IMPL_MASK);
  endproperty
  a_p3_data_write: assert property (p_p3_data_write)
    else $error("port 3 drive data differ from written latch");

  property p_p3_dir_reserved;
    s_write(`PPF_OFF_P3_DIR) |=> (state.port3_direction[5:3] == 3'h0);
  endproperty
  a_p3_dir_reserved: assert property (p_p3_dir_reserved)
    else $error("port 3 direction reserved bits modified");

  // a peripheral that owns a port 3 pin must never see the latch drive it
  property p_p3_alt;
    (port3_alt_func_in != 8'h00) |-> ((port3_pin_oe_out & port3_alt_func_in) == 8'h00);
  endproperty
  a_p3_alt: assert property (p_p3_alt)
    else $error("port 3 pin driven while owned by a peripheral");

  property p_capture;
    (timer_cfg_in.timer_mode_bits == `PPF_TMODE_NORMAL) && timer_cfg_in.timer_a_io_ctrl[3] |->
      (timer1_pin_a_capture_out == port1_pin_in[2]);
  endproperty
  a_capture: assert property (p_capture)
    else $error("a-pin level not routed to capture input");

  property p_ext_clock;
    (timer_cfg_in.clock_prescale_sel_1 == `PPF_TPSC_EXT_A) ||
      (timer_cfg_in.clock_prescale_sel_2 == `PPF_TPSC_EXT_A) |->
      (ext_timer_clock_a_out == port1_pin_in[2]);
  endproperty
  a_ext_clock: assert property (p_ext_clock)
    else $error("a-pin level not routed to external clock input");

  property p_compare_out;
    (timer_cfg_in.timer_mode_bits == `PPF_TMODE_NORMAL) && !timer_cfg_in.timer_a_io_ctrl[3] &&
      (timer_cfg_in.timer_a_io_ctrl[1:0] != 2'h0) |->
      port1_pin_oe_out[2] && (port1_pin_out[2] == timer1_pin_a_wave_in);
  endproperty
  a_compare_out: assert property (p_compare_out)
    else $error("compare output not on a-pin");

  // without a timer output the a-pin is plain io under its own bits
  property p_a_plain_io;
    !a_func.out_en |-> (port1_pin_oe_out[2] == state.port1_direction[2]) &&
      (port1_pin_out[2] == state.port1_data[2]);
  endproperty
  a_a_plain_io: assert property (p_a_plain_io)
    else $error("a-pin not general io without a timer output");

  property p_pwm1_only;
    (timer_cfg_in.timer_mode_bits != `PPF_TMODE_PWM1) |-> !timer1_pin_b_out_dis_out;
  endproperty
  a_pwm1_only: assert property (p_pwm1_only)
    else $error("b-pin output disabled outside pwm mode 1");

endmodule // ppf_top

// ==== tb/ppf_pin_model.sv ====
// board side of the port pins: resolves each pin from the block drive and an outside driver
// assumes the outside driver always holds a level, so an undriven pin never floats to x
`timescale 1ns/1ps

module ppf_pin_model (
  input  wire logic [2:0] p1_out_in,
  input  wire logic [2:0] p1_oe_in,
  input  wire logic [2:0] p1_ext_in,
  input  wire logic [7:0] p3_out_in,
  input  wire logic [7:0] p3_oe_in,
  input  wire logic [7:0] p3_ext_in,
  output      logic [2:0] p1_pin_out,
  output      logic [7:0] p3_pin_out
);
  // the block wins where it drives; contention with the outside driver is not modelled
  assign p1_pin_out = (p1_oe_in & p1_out_in) | (~p1_oe_in & p1_ext_in);
  assign p3_pin_out = (p3_oe_in & p3_out_in) | (~p3_oe_in & p3_ext_in);
endmodule // ppf_pin_model

// ==== tb/testbench.sv ====
// self-checking bench for the port function select block
// assumes ppf_top and the pin model are compiled first; one clock, no checker file
`timescale 1ns/1ps

module testbench;
  logic                    clock_in     = 1'b0;
  logic                    resetn_in    = 1'b0;
  logic [7:0]              reg_addr_in  = 8'h00;
  logic [7:0]              reg_wdata_in = 8'h00;
  logic                    reg_wr_in    = 1'b0;
  logic                    reg_rd_in    = 1'b0;
  ppf_pkg::ppf_timer_cfg_s timer_cfg_in = '0;
  logic                    wave         = 1'b1;
  logic [2:0]              p1_ext       = 3'h7;
  logic [7:0]              p3_ext       = 8'h5a;
  logic [7:0]              p3_alt       = 8'h00;
  logic [2:0]              p1_pin, p1_out, p1_oe;
  logic [7:0]              p3_pin, p3_out, p3_oe, rdata;
  logic [6:0]              pull;
  logic                    cap, eclk, bdis, evl, evh;
  int                      bad_count = 0;
  int                      checks = 0;

  // 100 mhz system clock
  always #5 clock_in = ~clock_in;

  ppf_top ppf_top_i (.clock_in(clock_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(rdata), .timer_cfg_in(timer_cfg_in), .timer1_pin_a_wave_in(wave),
    .timer1_pin_a_capture_out(cap), .ext_timer_clock_a_out(eclk),
    .timer1_pin_b_out_dis_out(bdis), .event_count_low_out(evl), .event_count_high_out(evh),
    .port1_pin_in(p1_pin), .port1_pin_out(p1_out), .port1_pin_oe_out(p1_oe),
    .port1_pullup_out(pull), .port3_pin_in(p3_pin), .port3_alt_func_in(p3_alt),
    .port3_pin_out(p3_out), .port3_pin_oe_out(p3_oe));

  ppf_pin_model ppf_pin_model_i (.p1_out_in(p1_out), .p1_oe_in(p1_oe), .p1_ext_in(p1_ext),
    .p3_out_in(p3_out), .p3_oe_in(p3_oe), .p3_ext_in(p3_ext), .p1_pin_out(p1_pin),
    .p3_pin_out(p3_pin));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one-cycle write; effect is settled 1 ns after the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask

  // read data only stand in the cycle after the strobe, so sample there
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic t_reset;
    logic [7:0] v;
    check({1'b0, pull}, 8'h00);
    check(p3_oe, 8'h00);
    rd(8'h07, v);
    check(v, 8'h00);
    rd(8'h05, v);
    check(v, 8'hff);
    @(posedge clock_in);
    #1;
    check(rdata, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_pullup;
    logic [7:0] p, d;
    for (int i = 0; i < 6; i++) begin
      p = 8'h7f >> (i / 2);
      d = (8'h0f << i) & 8'h7f;
      wr(8'h02, p);
      wr(8'h01, d);
      check({1'b0, pull}, ~d & p & 8'h7f);
    end
    $display("test pullup done");
  endtask

  task automatic t_port3;
    logic [7:0] v;
    wr(8'h05, 8'hff);
    wr(8'h04, 8'hff);
    check(p3_oe, 8'hc7);
    check(p3_out, 8'hc7);
    rd(8'h04, v);
    check(v, 8'hff);
    wr(8'h04, 8'ha5);
    wr(8'h05, 8'h81);
    rd(8'h04, v);
    check(v, (((8'ha5 & 8'h81) | (p3_ext & ~8'h81)) & 8'hc7) | 8'h38);
    check(p3_oe, 8'h81);
    @(posedge clock_in);
    p3_alt <= 8'h01;
    #1;
    check(p3_oe, 8'h80);
    rd(8'h05, v);
    check(v, 8'hff);
    @(posedge clock_in);
    p3_alt <= 8'h00;
    $display("test port3 done");
  endtask

  // walks every mode, io and clear code with both direction settings
  task automatic t_timer;
    ppf_pkg::ppf_timer_cfg_s c;
    logic [7:0] k;
    logic o, oe2, out2, pin2;
    for (int d = 0; d < 2; d++) begin
      wr(8'h00, 8'h00);
      wr(8'h01, (d == 1) ? 8'h04 : 8'h00);
      for (int n = 0; n < 256; n++) begin
        k = n[7:0];
        c = '{k[7:6], k[5:2], k[1:0], (k[1:0] == 2'h1) ? 3'h4 : 3'h0,
              (k[1:0] == 2'h3) ? 3'h4 : 3'h5};
        @(posedge clock_in);
        timer_cfg_in <= c;
        wave         <= ~wave;
        p1_ext[2]    <= k[0];
        #1;
        o = (k[7:6] == 2'h0 && k[5] == 1'b0 && k[4:2] != 3'h0 && k[4:2] != 3'h4)
          || (k[7:6] == 2'h2 && k[3:2] != 2'h0)
          || (k[7:6] == 2'h3 && k[3:2] != 2'h0 && k[1:0] != 2'h2);
        oe2 = o | (d == 1);
        out2 = o ? wave : 1'b0;
        pin2 = oe2 ? out2 : p1_ext[2];
        check({3'h0, p1_oe[2], p1_out[2], cap, eclk, bdis},
              {3'h0, oe2, out2, (k[7:6] == 2'h0 && k[5]) & pin2,
               (c.clock_prescale_sel_1 == 3'h4 || c.clock_prescale_sel_2 == 3'h4) & pin2,
               k[7:6] == 2'h2 && k[3:2] != 2'h0});
      end
    end
    $display("test timer pin done");
  endtask

  task automatic t_event;
    logic [1:0] m;
    logic [1:0] e;
    logic [7:0] v;
    wr(8'h00, 8'h00);
    wr(8'h01, 8'h03);
    for (int i = 0; i < 8; i++) begin
      m = i[1:0];
      e = {2{i[2]}};
      @(posedge clock_in);
      p1_ext[1:0] <= e;
      wr(8'h03, {6'h00, m});
      check({4'h0, p1_oe[1:0], evl, evh}, {4'h0, ~m, m & e});
      rd(8'h03, v);
      check(v, {6'h3f, m});
    end
    $display("test event pins done");
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // main sequence: reset held 8 cycles, then requests after the release flops settle
  initial begin
    repeat (8) @(posedge clock_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    #1;
    t_reset();
    t_pullup();
    // second reset with pull-ups on, so the reset value is really exercised
    @(posedge clock_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    #1;
    t_reset();
    t_port3();
    t_timer();
    t_event();
    finish_test();
  end

  // the whole run needs about 630 cycles; nearly twenty times that means a hang
  initial begin
    #120000;
    bad_count++;
    $display("watchdog expired at %0t", $time);
    finish_test();
  end
endmodule // testbench
